// File: epq_pkg.sv
package epq_pkg;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [9:0] EPQ_IDX_PORT_BASE = 10'h010;
	localparam logic [9:0] EPQ_IDX_TAGMAP0   = 10'h080;
	localparam logic [9:0] EPQ_IDX_TAGMAP1   = 10'h081;
	localparam logic [9:0] EPQ_IDX_QMAP      = 10'h082;
	localparam logic [9:0] EPQ_IDX_DS_BASE   = 10'h090;
	localparam logic [9:0] EPQ_DS_REGS       = 10'h010;
	localparam logic [3:0] EPQ_SUB_CTRL0     = 4'h0;
	localparam logic [3:0] EPQ_SUB_CTRL9     = 4'h9;
	localparam logic [3:0] EPQ_SUB_WGT_FIRST = 4'hA;
	localparam logic [3:0] EPQ_SUB_WGT_LAST  = 4'hD;
	localparam logic [3:0] EPQ_SUB_STATUS    = 4'hE;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int EPQ_C0_SPLIT2  = 0;
	localparam int EPQ_C0_PRIO_LO = 3;
	localparam int EPQ_C0_DOT1P   = 5;
	localparam int EPQ_C9_SPLIT4  = 1;
	localparam int EPQ_C9_WFQ     = 3;
	localparam int EPQ_QM_DS_EN   = 0;
	localparam int EPQ_QM_MAP_LO  = 6;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] EPQ_RST_CTRL0   = 8'h00;
	localparam logic [7:0] EPQ_RST_CTRL9   = 8'h00;
	localparam logic [7:0] EPQ_RST_TAGMAP0 = 8'h50;
	localparam logic [7:0] EPQ_RST_TAGMAP1 = 8'hFA;
	localparam logic [7:0] EPQ_RST_QMAP    = 8'h00;
	localparam logic [7:0] EPQ_RST_DS      = 8'h00;
	localparam logic [6:0] EPQ_RST_WGT3    = 7'h08;
	localparam logic [6:0] EPQ_RST_WGT2    = 7'h04;
	localparam logic [6:0] EPQ_RST_WGT1    = 7'h02;
	localparam logic [6:0] EPQ_RST_WGT0    = 7'h01;
	// ****************************************
	// Queue split modes
	// ****************************************
	localparam logic [1:0] EPQ_MODE_ONE  = 2'b00;
	localparam logic [1:0] EPQ_MODE_TWO  = 2'b01;
	localparam logic [1:0] EPQ_MODE_FOUR = 2'b10;
endpackage

// File: epq_fifo.sv
`timescale 1ns/1ps
module epq_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Fill side
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire logic [W-1:0] wr_data,
	// Drain side
	output logic              rd_valid,
	input  wire logic         rd_ready,
	output logic [W-1:0]      rd_data
);
	localparam int AW = $clog2(D);

	if (D < 2 || (1 << AW) != D) begin : g_bad_depth
		$error("epq_fifo depth must be a power of two");
	end

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW-1:0] rp_nxt;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign wr_ready = (cnt_r != (AW+1)'(D));
	assign rd_valid = (cnt_r != '0);
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;
	assign rp_nxt   = pop ? rp_r + 1'b1 : rp_r;

	// Head word kept in a register; a word landing in the slot that
	// becomes the head goes straight there, so order is never lost
	always_ff @(posedge pclk) begin
		if (push)
			mem[wp_r] <= wr_data;
		if (push && wp_r == rp_nxt)
			rd_data <= wr_data;
		else
			rd_data <= mem[rp_nxt];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// File: epq_sched.sv
`timescale 1ns/1ps
module epq_sched #(
	parameter int NQ = 4,
	parameter int WW = 7
) (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Queue state and policy
	input  wire logic [NQ-1:0]   q_valid,
	input  wire logic            wfq_en,
	input  wire logic [NQ*WW-1:0] weights,
	// Grant
	input  wire logic            take,
	output logic                 sel_valid,
	output logic [1:0]           sel
);
	if (NQ != 4) begin : g_bad_nq
		$error("epq_sched serves exactly four queues");
	end

	logic [WW-1:0] credit_r [NQ];
	logic [NQ-1:0] elig;
	logic          reload;

	function automatic logic [1:0] top_pick(input logic [NQ-1:0] v);
		logic [1:0] r;
		r = '0;
		for (int i = 0; i < NQ; i++)
			if (v[i])
				r = 2'(i);
		return r;
	endfunction

	always_comb begin
		for (int i = 0; i < NQ; i++)
			elig[i] = q_valid[i] && (credit_r[i] != '0);
	end

	// Credits run dry: every queue, backlogged or idle, gets its weight back
	assign reload    = wfq_en && (elig == '0);
	assign sel_valid = (q_valid != '0);
	// Queue 3 wins in strict mode, lowest index loses
	assign sel = (wfq_en && !reload) ? top_pick(elig) : top_pick(q_valid);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NQ; i++)
				credit_r[i] <= '0;
		end else if (take && wfq_en) begin
			for (int i = 0; i < NQ; i++) begin
				if (reload)
					credit_r[i] <= weights[i*WW +: WW] -
						WW'(2'(i) == sel && weights[i*WW +: WW] != '0);
				else if (2'(i) == sel)
					credit_r[i] <= credit_r[i] - 1'b1;
			end
		end
	end

	a_strict_top_queue: assert property (@(posedge pclk) disable iff (!presetn)
		(sel_valid && !wfq_en) |-> ((q_valid >> sel) == 1))
		else $error("strict pick skipped a higher queue");
	a_wfq_credit_use: assert property (@(posedge pclk) disable iff (!presetn)
		(take && wfq_en && !reload) |=>
		credit_r[$past(sel)] == $past(credit_r[sel]) - 1'b1)
		else $error("weighted grant did not spend a credit");
	c_wfq_reload: cover property (@(posedge pclk) disable iff (!presetn)
		take && reload);
endmodule

// File: epq_classifier.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - Two-bit split picks one, two, four queues
// - Split bits held separately for each port
// - Queue 3 highest, queue 0 lowest
// - Unsplit port treats all priorities alike
// - Strict or weighted service, weights 8,4,2,1
// - Two-queue map turns level into high/low
// - Port level from control zero field
// - Level three frames go high queue
// - Tagged frames yield three-bit priority
// - Tag priority mapped through two registers
// - Tag classification only when enabled
// - Code point looked up in 128-bit table
module epq_classifier
	import epq_pkg::*;
#(
	parameter int NPORT = 5,
	parameter int DW    = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Ingress frames from forwarding engine
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire logic [2:0]          in_src_port,
	input  wire logic [2:0]          in_dst_port,
	input  wire logic                in_tagged,
	input  wire logic [2:0]          in_tag_prio,
	input  wire logic                in_ip,
	input  wire logic [7:0]          in_ip_service_type_field,
	input  wire logic [DW-1:0]       in_desc,
	// Egress transmitters
	output logic [NPORT-1:0]         eg_valid,
	input  wire logic [NPORT-1:0]    eg_ready,
	output logic [NPORT*DW-1:0]      eg_desc,
	output logic [NPORT*2-1:0]       eg_queue
);
	localparam int NQ = 4;
	localparam logic [9:0] PORT_END =
		EPQ_IDX_PORT_BASE + 10'(16 * NPORT);

	if (NPORT < 1 || NPORT > 7) begin : g_bad_nport
		$error("epq_classifier serves one to seven ports");
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] ctrl0_r [NPORT];
	logic [7:0] ctrl9_r [NPORT];
	logic [6:0] wgt_r   [NPORT][NQ];
	logic [7:0] tagmap_r [2];
	logic [7:0] qmap_r;
	logic [7:0] ds_r [16];
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic [NQ-1:0] nonempty [NPORT];

	logic [9:0] idx;
	logic [9:0] pidx;
	logic       in_port_range;
	logic       in_ds_range;
	logic       wr_go;

	assign idx           = paddr[11:2];
	assign pidx          = idx - EPQ_IDX_PORT_BASE;
	assign in_port_range = idx >= EPQ_IDX_PORT_BASE && idx < PORT_END;
	assign in_ds_range   = idx >= EPQ_IDX_DS_BASE &&
		idx < EPQ_IDX_DS_BASE + EPQ_DS_REGS;
	// No wait states: read data was captured in the setup cycle
	assign pready        = 1'b1;
	assign prdata        = prdata_r;
	assign pslverr       = pslverr_r;
	assign wr_go         = psel && penable && pwrite && !pslverr_r;

	// Register 10 weighs queue 3, register 13 weighs queue 0
	function automatic logic [1:0] wgt_queue(input logic [3:0] sub);
		return 2'(EPQ_SUB_WGT_LAST - sub);
	endfunction

	function automatic logic is_mapped(input logic [9:0] i);
		logic [3:0] s;
		s = 4'(i - EPQ_IDX_PORT_BASE);
		if (i >= EPQ_IDX_PORT_BASE && i < PORT_END)
			return s == EPQ_SUB_CTRL0 || s == EPQ_SUB_CTRL9 ||
				s == EPQ_SUB_STATUS ||
				(s >= EPQ_SUB_WGT_FIRST && s <= EPQ_SUB_WGT_LAST);
		return i == EPQ_IDX_TAGMAP0 || i == EPQ_IDX_TAGMAP1 ||
			i == EPQ_IDX_QMAP ||
			(i >= EPQ_IDX_DS_BASE && i < EPQ_IDX_DS_BASE + EPQ_DS_REGS);
	endfunction

	function automatic logic [31:0] rd_word(input logic [9:0] i);
		logic [9:0] p;
		logic [3:0] s;
		logic [2:0] n;
		p = i - EPQ_IDX_PORT_BASE;
		s = p[3:0];
		n = p[6:4];
		rd_word = 32'h0000_0000;
		if (i >= EPQ_IDX_PORT_BASE && i < PORT_END) begin
			if (s == EPQ_SUB_CTRL0)
				rd_word = {24'h00_0000, ctrl0_r[n]};
			else if (s == EPQ_SUB_CTRL9)
				rd_word = {24'h00_0000, ctrl9_r[n]};
			else if (s == EPQ_SUB_STATUS)
				rd_word = {28'h000_0000, nonempty[n]};
			else if (s >= EPQ_SUB_WGT_FIRST && s <= EPQ_SUB_WGT_LAST)
				rd_word = {25'h000_0000, wgt_r[n][wgt_queue(s)]};
		end else if (i == EPQ_IDX_TAGMAP0)
			rd_word = {24'h00_0000, tagmap_r[0]};
		else if (i == EPQ_IDX_TAGMAP1)
			rd_word = {24'h00_0000, tagmap_r[1]};
		else if (i == EPQ_IDX_QMAP)
			rd_word = {24'h00_0000, qmap_r};
		else if (i >= EPQ_IDX_DS_BASE && i < EPQ_IDX_DS_BASE + EPQ_DS_REGS)
			rd_word = {24'h00_0000, ds_r[4'(i - EPQ_IDX_DS_BASE)]};
	endfunction

	// ****************************************
	// APB answer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_word(idx);
			pslverr_r <= !is_mapped(idx);
		end else if (psel && penable) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	// ****************************************
	// Per-port registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NPORT; p++) begin
				ctrl0_r[p]  <= EPQ_RST_CTRL0;
				ctrl9_r[p]  <= EPQ_RST_CTRL9;
				wgt_r[p][3] <= EPQ_RST_WGT3;
				wgt_r[p][2] <= EPQ_RST_WGT2;
				wgt_r[p][1] <= EPQ_RST_WGT1;
				wgt_r[p][0] <= EPQ_RST_WGT0;
			end
		end else if (wr_go && in_port_range) begin
			// Each port owns its own split bits
			if (pidx[3:0] == EPQ_SUB_CTRL0)
				ctrl0_r[pidx[6:4]] <= pwdata[7:0];
			else if (pidx[3:0] == EPQ_SUB_CTRL9)
				ctrl9_r[pidx[6:4]] <= pwdata[7:0];
			else if (pidx[3:0] >= EPQ_SUB_WGT_FIRST &&
					pidx[3:0] <= EPQ_SUB_WGT_LAST)
				wgt_r[pidx[6:4]][wgt_queue(pidx[3:0])] <= pwdata[6:0];
		end
	end

	// ****************************************
	// Shared mapping registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tagmap_r[0] <= EPQ_RST_TAGMAP0;
			tagmap_r[1] <= EPQ_RST_TAGMAP1;
			qmap_r      <= EPQ_RST_QMAP;
			for (int i = 0; i < 16; i++)
				ds_r[i] <= EPQ_RST_DS;
		end else if (wr_go) begin
			if (idx == EPQ_IDX_TAGMAP0)
				tagmap_r[0] <= pwdata[7:0];
			else if (idx == EPQ_IDX_TAGMAP1)
				tagmap_r[1] <= pwdata[7:0];
			else if (idx == EPQ_IDX_QMAP)
				qmap_r <= pwdata[7:0];
			else if (in_ds_range)
				ds_r[4'(idx - EPQ_IDX_DS_BASE)] <= pwdata[7:0];
		end
	end

	// ****************************************
	// Classification
	// ****************************************
	logic [1:0] tag_level;
	logic [1:0] ds_level;
	logic [1:0] port_level;
	logic [1:0] level;
	logic [1:0] qmode;
	logic [1:0] qsel;
	logic [5:0] code_point;
	logic       use_tag;
	logic       use_ds;
	logic       dst_ok;
	logic       src_ok;
	logic [2:0] src;
	logic [2:0] dst;
	logic [NPORT*NQ-1:0] fq_ready;

	assign src_ok = in_src_port < 3'(NPORT);
	assign dst_ok = in_dst_port < 3'(NPORT);
	assign src    = src_ok ? in_src_port : 3'h0;
	assign dst    = dst_ok ? in_dst_port : 3'h0;

	// Map a level into the two-queue split
	function automatic logic two_q_high(input logic [1:0] lv,
			input logic [1:0] m);
		return lv == 2'h3 || lv >= 2'h3 - m;
	endfunction

	always_comb begin
		tag_level  = tagmap_r[in_tag_prio[2]][{in_tag_prio[1:0], 1'b0} +: 2];
		code_point = in_ip_service_type_field[7:2];
		ds_level   = ds_r[code_point[5:2]][{code_point[1:0], 1'b0} +: 2];
		port_level = ctrl0_r[src][EPQ_C0_PRIO_LO +: 2];
		use_tag    = in_tagged && ctrl0_r[src][EPQ_C0_DOT1P];
		use_ds     = in_ip && qmap_r[EPQ_QM_DS_EN];
		level      = use_tag ? tag_level : use_ds ? ds_level : port_level;
		qmode      = {ctrl9_r[dst][EPQ_C9_SPLIT4],
			ctrl0_r[dst][EPQ_C0_SPLIT2]};
		case (qmode)
			EPQ_MODE_TWO:
				qsel = {1'b0, two_q_high(level,
					qmap_r[EPQ_QM_MAP_LO +: 2])};
			EPQ_MODE_FOUR:
				qsel = level;
			default:
				qsel = 2'h0;
		endcase
	end

	// Frames to a port that does not exist are dropped
	// Index is port times four plus queue, built wide enough for all ports
	assign in_ready = !dst_ok || fq_ready[{dst, qsel}];

	// ****************************************
	// Queues, schedulers and output stages
	// ****************************************
	logic [DW-1:0] out_desc_r [NPORT];
	logic [1:0]    out_q_r    [NPORT];
	logic [NPORT-1:0] out_v_r;

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic [NQ-1:0] qv;
		logic [DW-1:0] qd [NQ];
		logic [NQ-1:0] pop;
		logic          sv;
		logic [1:0]    sq;
		logic          load;
		logic [NQ*7-1:0] wflat;

		assign load        = sv && (!out_v_r[p] || eg_ready[p]);
		assign nonempty[p] = qv;

		for (genvar q = 0; q < NQ; q++) begin : g_q
			assign pop[q] = load && sq == 2'(q);
			assign wflat[q*7 +: 7] = wgt_r[p][q];
			epq_fifo #(.W(DW), .D(DEPTH)) u_fifo (
				.pclk    (pclk),
				.presetn (presetn),
				.wr_valid(in_valid && dst_ok && dst == 3'(p) &&
					qsel == 2'(q)),
				.wr_ready(fq_ready[p*NQ+q]),
				.wr_data (in_desc),
				.rd_valid(qv[q]),
				.rd_ready(pop[q]),
				.rd_data (qd[q])
			);
		end

		epq_sched #(.NQ(NQ), .WW(7)) u_sched (
			.pclk     (pclk),
			.presetn  (presetn),
			.q_valid  (qv),
			.wfq_en   (ctrl9_r[p][EPQ_C9_WFQ]),
			.weights  (wflat),
			.take     (load),
			.sel_valid(sv),
			.sel      (sq)
		);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				out_v_r[p]    <= 1'b0;
				out_desc_r[p] <= '0;
				out_q_r[p]    <= 2'h0;
			end else if (load) begin
				out_v_r[p]    <= 1'b1;
				out_desc_r[p] <= qd[sq];
				out_q_r[p]    <= sq;
			end else if (eg_ready[p]) begin
				out_v_r[p]    <= 1'b0;
			end
		end

		assign eg_valid[p]            = out_v_r[p];
		assign eg_desc[p*DW +: DW]    = out_desc_r[p];
		assign eg_queue[p*2 +: 2]     = out_q_r[p];

		a_out_hold_stall: assert property (@(posedge pclk)
			disable iff (!presetn)
			(eg_valid[p] && !eg_ready[p]) |=>
			(eg_valid[p] && $stable(eg_desc[p*DW +: DW])))
			else $error("egress frame changed while stalled");
	end

	// ****************************************
	// Checks
	// ****************************************
	logic enq;
	assign enq = in_valid && in_ready && dst_ok;

	a_one_queue_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && qmode == EPQ_MODE_ONE) |-> qsel == 2'h0)
		else $error("unsplit port used a queue other than zero");
	a_four_queue_lvl: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && qmode == EPQ_MODE_FOUR) |-> qsel == level)
		else $error("four-queue port did not follow level");
	a_prio3_high: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && qmode == EPQ_MODE_TWO && level == 2'h3) |-> qsel == 2'h1)
		else $error("level three frame missed high queue");
	a_port_level_use: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && !in_tagged && !in_ip) |->
		level == ctrl0_r[src][4:3])
		else $error("port level not applied");
	a_tag_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && in_tagged && !ctrl0_r[src][5] && !in_ip) |->
		level == port_level)
		else $error("tag priority used while disabled");
	a_tag_map_lookup: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && in_tagged && ctrl0_r[src][5] && in_tag_prio == 3'h7) |->
		level == tagmap_r[1][7:6])
		else $error("tag priority seven mapped wrongly");
	a_ds_lookup: assert property (@(posedge pclk) disable iff (!presetn)
		(enq && use_ds && !use_tag && code_point == 6'h00) |->
		level == ds_r[0][1:0])
		else $error("code point zero mapped wrongly");
	a_ctrl0_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && idx == EPQ_IDX_PORT_BASE) |=>
		ctrl0_r[0] == $past(pwdata[7:0]))
		else $error("port zero control write lost");

	c_four_queue: cover property (@(posedge pclk) disable iff (!presetn)
		enq && qmode == EPQ_MODE_FOUR && qsel == 2'h3);
	c_two_queue: cover property (@(posedge pclk) disable iff (!presetn)
		enq && qmode == EPQ_MODE_TWO && qsel == 2'h1);
	c_stall_full: cover property (@(posedge pclk) disable iff (!presetn)
		in_valid && !in_ready);
endmodule

// File: epq_eg_model.sv
`timescale 1ns/1ps
module epq_eg_model #(
	parameter int NPORT = 5,
	parameter int DW    = 16
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Egress side of the block
	input  wire logic [NPORT-1:0]    eg_valid,
	output logic [NPORT-1:0]         eg_ready,
	input  wire logic [NPORT*DW-1:0] eg_desc,
	input  wire logic [NPORT*2-1:0]  eg_queue,
	// Bench control and report
	input  wire logic [NPORT-1:0]    stall,
	input  wire logic                slow,
	output logic                     got,
	output logic [2:0]               got_port,
	output logic [DW-1:0]            got_desc,
	output logic [1:0]               got_queue
);
	logic [7:0] lf_r;
	// ****************************************
	// Transmitter pacing
	// ****************************************
	// Ready is registered, so a stall lands one cycle late, like a real MAC
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_r     <= 8'h5A;
			eg_ready <= '0;
		end else begin
			lf_r     <= {lf_r[6:0], lf_r[7] ^ lf_r[5] ^ lf_r[4] ^ lf_r[3]};
			eg_ready <= ~stall & {NPORT{~slow | lf_r[0]}};
		end
	end
	// ****************************************
	// Hand-off capture
	// ****************************************
	// Only one port is reported per cycle; the bench keeps one port busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			got       <= 1'b0;
			got_port  <= 3'h0;
			got_desc  <= '0;
			got_queue <= 2'h0;
		end else begin
			got <= 1'b0;
			for (int p = 0; p < NPORT; p++) begin
				if (eg_valid[p] && eg_ready[p]) begin
					got       <= 1'b1;
					got_port  <= 3'(p);
					got_desc  <= eg_desc[p*DW +: DW];
					got_queue <= eg_queue[p*2 +: 2];
				end
			end
		end
	end
endmodule

// File: egress_priority_queue_classifier_tb_top.sv
`timescale 1ns/1ps
module egress_priority_queue_classifier_tb_top;
	import epq_pkg::*;
	localparam int NP  = 5;
	localparam int DW  = 16;
	localparam int TMO = 20000;
	localparam logic [9:0] PB = EPQ_IDX_PORT_BASE;
	localparam logic [9:0] RI [9] = '{PB, PB + 10'h049, PB + 10'h00A,
		PB + 10'h00B, PB + 10'h00C, PB + 10'h00D, EPQ_IDX_TAGMAP0,
		EPQ_IDX_TAGMAP1, EPQ_IDX_QMAP};
	localparam logic [7:0] RV [9] = '{EPQ_RST_CTRL0, EPQ_RST_CTRL9,
		8'(EPQ_RST_WGT3), 8'(EPQ_RST_WGT2), 8'(EPQ_RST_WGT1),
		8'(EPQ_RST_WGT0), EPQ_RST_TAGMAP0, EPQ_RST_TAGMAP1, EPQ_RST_QMAP};
	localparam int EO [5] = '{0, 4, 3, 2, 1};
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             in_valid, in_ready, in_tagged, in_ip, slow, got, er;
	logic [2:0]       in_src_port, in_dst_port, in_tag_prio, got_port;
	logic [7:0]       in_ip_service_type_field;
	logic [DW-1:0]    in_desc, got_desc, dv;
	logic [NP-1:0]    eg_valid, eg_ready, stall, ten;
	logic [NP*DW-1:0] eg_desc;
	logic [NP*2-1:0]  eg_queue;
	logic [1:0]       got_queue, m, q;
	logic [1:0]       tmap [8];
	logic [1:0]       ds [64];
	logic [1:0]       plvl [NP];
	logic [1:0]       mode [NP];
	logic             ds_en;
	logic [15:0]      seed, v;
	int               errors, compares;
	int               cyc = 0;
	epq_classifier #(.NPORT(NP), .DW(DW), .DEPTH(8)) epq_classifier_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid),
		.in_ready(in_ready), .in_src_port(in_src_port),
		.in_dst_port(in_dst_port), .in_tagged(in_tagged),
		.in_tag_prio(in_tag_prio), .in_ip(in_ip),
		.in_ip_service_type_field(in_ip_service_type_field),
		.in_desc(in_desc), .eg_valid(eg_valid), .eg_ready(eg_ready),
		.eg_desc(eg_desc), .eg_queue(eg_queue));
	epq_eg_model #(.NPORT(NP), .DW(DW)) epq_eg_model_i (
		.pclk(pclk), .presetn(presetn), .eg_valid(eg_valid),
		.eg_ready(eg_ready), .eg_desc(eg_desc), .eg_queue(eg_queue),
		.stall(stall), .slow(slow), .got(got), .got_port(got_port),
		.got_desc(got_desc), .got_queue(got_queue));
	// ****************************************
	// Checking and helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [9:0] preg(input int p, input logic [3:0] n);
		return PB + 10'(16 * p) + 10'(n);
	endfunction
	// Tag beats code point beats port level; unsplit and mode 11 give queue 0
	function automatic logic [1:0] exp_q(input int p, input int d,
		input logic tg, input logic [2:0] tp, input logic ip,
		input logic [5:0] cp);
		logic [1:0] l;
		l = plvl[p];
		if (ds_en && ip)
			l = ds[cp];
		if (ten[p] && tg)
			l = tmap[tp];
		case (mode[d])
			EPQ_MODE_FOUR: return l;
			EPQ_MODE_TWO:  return {1'b0, l >= 2'(3 - m)};
			default:       return 2'b00;
		endcase
	endfunction
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [31:0] wd, output logic [31:0] rdv, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		e   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input int s, input int d, input logic tg,
		input logic [2:0] tp, input logic ip, input logic [7:0] ip_service_type_field,
		input logic [DW-1:0] dsc);
		@(posedge pclk);
		in_valid                 <= 1'b1;
		in_src_port              <= 3'(s);
		in_dst_port              <= 3'(d);
		in_tagged                <= tg;
		in_tag_prio              <= tp;
		in_ip                    <= ip;
		in_ip_service_type_field <= ip_service_type_field;
		in_desc                  <= dsc;
		do @(posedge pclk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
	endtask
	task automatic take(input int d, input logic [1:0] eq,
		input logic [DW-1:0] ed);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (got !== 1'b1 && n < 200);
		chk(32'(got), 32'h1);
		chk(32'(got_port), 32'(d));
		chk(32'(got_queue), 32'(eq));
		chk(32'(got_desc), 32'(ed));
	endtask
	task automatic cfg;
		for (int t = 0; t < 8; t++) begin
			seed = lfsr(seed);
			tmap[t] = seed[1:0];
		end
		apb(1'b1, EPQ_IDX_TAGMAP0, {24'h0, tmap[3], tmap[2], tmap[1], tmap[0]},
			rd, er);
		apb(1'b1, EPQ_IDX_TAGMAP1, {24'h0, tmap[7], tmap[6], tmap[5], tmap[4]},
			rd, er);
		for (int r = 0; r < 16; r++) begin
			for (int k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				ds[4*r+k] = seed[1:0];
			end
			apb(1'b1, EPQ_IDX_DS_BASE + 10'(r), {24'h0, ds[4*r+3], ds[4*r+2],
				ds[4*r+1], ds[4*r]}, rd, er);
		end
		seed = lfsr(seed);
		m = seed[7:6];
		ds_en = seed[0];
		apb(1'b1, EPQ_IDX_QMAP, {24'h0, m, 5'h00, ds_en}, rd, er);
		for (int p = 0; p < NP; p++) begin
			seed = lfsr(seed);
			mode[p] = seed[1:0];
			plvl[p] = seed[3:2];
			ten[p] = seed[4];
			apb(1'b1, preg(p, EPQ_SUB_CTRL0),
				{26'h0, ten[p], plvl[p], 2'b00, mode[p][0]}, rd, er);
			apb(1'b1, preg(p, EPQ_SUB_CTRL9),
				{28'h0, seed[5], 1'b0, mode[p][1], 1'b0}, rd, er);
		end
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == TMO) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, in_valid, in_tagged, in_ip} = '0;
		{paddr, pwdata, in_src_port, in_dst_port, in_tag_prio} = '0;
		in_ip_service_type_field = 8'h00;
		in_desc = '0;
		stall = '0;
		slow = 1'b0;
		seed = 16'h0029;
		errors = 0;
		compares = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, RI[i], 32'h0, rd, er);
			chk(rd, 32'(RV[i]));
		end
		apb(1'b0, 10'h3FF, 32'h0, rd, er);
		chk(32'(er), 32'h1);
		apb(1'b1, preg(1, EPQ_SUB_STATUS), 32'h0000000F, rd, er);
		chk(32'(er), 32'h0);
		// Weight field is seven bits wide, the top bit is dropped
		apb(1'b1, preg(1, EPQ_SUB_WGT_FIRST), 32'h000000FF, rd, er);
		apb(1'b0, preg(1, EPQ_SUB_WGT_FIRST), 32'h0, rd, er);
		chk(rd, 32'h0000007F);
		// Stalled egress holds one frame per queue plus a queue 3 frame in the output stage
		for (int p = 0; p < 4; p++)
			apb(1'b1, preg(p, EPQ_SUB_CTRL0), 32'(p << 3), rd, er);
		for (int wf = 0; wf < 2; wf++) begin
			apb(1'b1, preg(2, EPQ_SUB_CTRL9), 32'(8 * wf + 2), rd, er);
			stall <= 5'b00100;
			for (int k = 0; k < 5; k++)
				send((k + 3) % 4, 2, 1'b0, 3'h0, 1'b0, 8'h00, 16'(16'hA0 + k));
			apb(1'b0, preg(2, EPQ_SUB_STATUS), 32'h0, rd, er);
			chk(rd, 32'h0000000F);
			stall <= '0;
			for (int k = 0; k < 5; k++)
				take(2, 2'((EO[k] + 3) % 4), 16'(16'hA0 + EO[k]));
		end
		// Fill one queue until refused, then drain while the offer is held
		stall <= 5'b01000;
		// One frame sits in the output stage, eight more fill the queue
		for (int k = 0; k < 9; k++)
			send(1, 3, 1'b0, 3'h0, 1'b0, 8'h00, 16'(16'hB0 + k));
		@(posedge pclk);
		in_valid <= 1'b1;
		in_desc  <= 16'hB9;
		repeat (3) @(posedge pclk);
		chk(32'(in_ready), 32'h0);
		stall <= '0;
		fork
			begin
				do @(posedge pclk); while (in_ready !== 1'b1);
				in_valid <= 1'b0;
			end
			for (int k = 0; k < 10; k++)
				take(3, 2'b00, 16'(16'hB0 + k));
		join
		for (int r = 0; r < 3; r++) begin
			cfg();
			slow <= r[0];
			for (int i = 0; i < 20; i++) begin
				seed = lfsr(seed);
				v = seed;
				seed = lfsr(seed);
				dv = seed;
				q = exp_q(v % NP, v[7:4] % NP, v[8], v[11:9], v[12], seed[7:2]);
				send(v % NP, v[7:4] % NP, v[8], v[11:9], v[12], seed[7:0], dv);
				take(v[7:4] % NP, q, dv);
			end
		end
		end_of_test();
	end
endmodule
